// file: sim/pif_host_model.sv
`timescale 1ns/1ps
module pif_host_model (
  // Clock
  input wire logic  clk,
  // Frame byte stream
  output logic       rx_valid,
  output logic [7:0] rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // Sends one frame, optionally with a broken checksum
  task automatic send(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] bank,
                      input logic [31:0] val, input logic bad);
    logic [7:0] f [9];
    logic [7:0] sum;
    f = '{pif_pkg::MODULE_ADDR, op, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum += f[i];
    f[8] = bad ? ~sum : sum;
    for (int i = 0; i < 9; i++) begin
      rx_valid <= 1'b1;
      rx_byte <= f[i];
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_byte <= ~f[8];
    @(posedge clk);
  endtask
endmodule // pif_host_model

// file: sim/pif_props.sv
`timescale 1ns/1ps
module pif_props (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     rst_n,
  // Watched ports
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic                     avs_waitrequest,
  input wire logic [31:0]              avs_readdata,
  input wire logic                     reply_valid,
  input wire logic [7:0]               reply_status,
  input wire logic                     jump_valid,
  input wire logic [pif_pkg::PC_W-1:0] jump_pc,
  input wire logic                     restore_valid,
  input wire pif_pkg::pif_ctx_t        restore_ctx
);
  logic in_h_ff;
  logic nxt_in_h;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Tracks a running handler
  always_comb nxt_in_h = jump_valid ? 1'b1 : (restore_valid ? 1'b0 : in_h_ff);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) in_h_ff <= 1'b0;
    else in_h_ff <= nxt_in_h;
  end
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_bus; s_req |=> s_ack; endproperty
  property p_rd_hold; !(avs_read && !avs_waitrequest) |-> $stable(avs_readdata); endproperty
  property p_reply; reply_valid |=> !reply_valid; endproperty
  property p_reply_hold; !reply_valid |-> $stable(reply_status); endproperty
  property p_jump; jump_valid |=> !jump_valid; endproperty
  property p_jump_hold; !jump_valid |-> $stable(jump_pc); endproperty
  property p_no_nest; jump_valid |-> !in_h_ff; endproperty
  property p_ret; restore_valid |-> in_h_ff ##1 !restore_valid; endproperty
  property p_rest_hold; !restore_valid |-> $stable(restore_ctx); endproperty
  a_bus: assert property (p_bus) else $error("bus answer not after one wait cycle");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a read");
  a_reply: assert property (p_reply) else $error("reply strobe too long");
  a_reply_hold: assert property (p_reply_hold) else $error("reply status moved");
  a_jump: assert property (p_jump) else $error("jump strobe too long");
  a_jump_hold: assert property (p_jump_hold) else $error("jump address moved");
  a_no_nest: assert property (p_no_nest) else $error("handler entered inside handler");
  a_ret: assert property (p_ret) else $error("restore without handler");
  a_rest_hold: assert property (p_rest_hold) else $error("restored context moved");
endmodule // pif_props
bind pif_top pif_props chk_u (.clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .avs_readdata,
  .reply_valid, .reply_status, .jump_valid, .jump_pc, .restore_valid, .restore_ctx);

// file: sim/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic                clk, rst_n, avs_read, avs_write, avs_waitrequest, irq, rx_valid;
  logic                reply_valid, prog_valid, jump_valid, restore_valid;
  logic [7:0]          avs_address, rx_byte, reply_status, reply_cmd, irq_src_pin;
  logic [31:0]         avs_writedata, avs_readdata;
  logic [3:0]          avs_byteenable;
  logic [15:0]         jump_pc;
  logic [4:0]          err_set, err_flags;
  pif_pkg::pif_cmd_t   prog_cmd;
  pif_pkg::pif_ctx_t   ctx_in, restore_ctx, c1, c2;
  int                  mismatches, compares, cyc;
  logic [15:0]         q_rep[$], q_jmp[$];
  logic [31:0]         q_rd[$];
  pif_pkg::pif_ctx_t   q_rst[$];

  pif_top dut_u (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .irq, .rx_valid, .rx_byte, .reply_valid, .reply_status, .reply_cmd,
    .prog_valid, .prog_cmd, .ctx_in, .jump_valid, .jump_pc, .restore_valid, .restore_ctx, .irq_src_pin,
    .err_set, .err_flags);
  pif_host_model host_u (.clk, .rx_valid, .rx_byte);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim;
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end

  // Takes the oldest note whenever a result shows
  always @(posedge clk) begin
    if (reply_valid === 1'b1) begin
      `CHK("reply", (q_rep.size() > 0) ? q_rep[0] : 16'hxxxx, {reply_status, reply_cmd})
      if (q_rep.size() > 0) void'(q_rep.pop_front());
    end
    if (jump_valid === 1'b1) begin
      `CHK("jump_pc", (q_jmp.size() > 0) ? q_jmp[0] : 16'hxxxx, jump_pc)
      if (q_jmp.size() > 0) void'(q_jmp.pop_front());
    end
    if (restore_valid === 1'b1) begin
      `CHK("restore", (q_rst.size() > 0) ? q_rst[0] : 88'hx, restore_ctx)
      if (q_rst.size() > 0) void'(q_rst.pop_front());
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      `CHK("readdata", (q_rd.size() > 0) ? q_rd[0] : 32'hx, avs_readdata)
      if (q_rd.size() > 0) void'(q_rd.pop_front());
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (q_rep.size() + q_jmp.size() + q_rd.size() + q_rst.size() != 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK("drain", 1'b0, n >= 100)
    repeat (2) @(posedge clk);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] typ, input logic [7:0] st);
    q_rep.push_back({st, op});
    host_u.send(op, typ, 8'($urandom), $urandom, st == pif_pkg::STS_BAD_CSUM);
    drain();
  endtask

  task automatic pg(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] v);
    prog_cmd <= '{op, typ, 8'($urandom), v};
    prog_valid <= 1'b1;
    @(posedge clk);
    prog_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input int n);
    irq_src_pin[n] <= 1'b1;
    repeat (6) @(posedge clk);
    irq_src_pin[n] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    {avs_read, avs_write, prog_valid, rst_n} = '0;
    avs_address = 8'h00;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    prog_cmd = '0;
    ctx_in = '0;
    irq_src_pin = '0;
    err_set = '0;
    mismatches = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(8));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Registers and interrupt line
    rd(pif_pkg::REG_MASK, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, pif_pkg::REG_MASK, 32'h1);
    rd(pif_pkg::REG_MASK, 32'h1);
    // Mask write without lane 0 is ignored
    avs_byteenable <= 4'he;
    bus(1'b1, pif_pkg::REG_MASK, 32'h0);
    avs_byteenable <= 4'hf;
    rd(pif_pkg::REG_MASK, 32'h1);
    cmd(pif_pkg::OP_CLEAR_FLAGS, pif_pkg::CLR_ALL, pif_pkg::STS_OK);
    `CHK("irq", 1'b1, irq)
    rd(pif_pkg::REG_EVENT, 32'h1);
    rd(pif_pkg::REG_EVENT, 32'h0);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, pif_pkg::REG_MASK, 32'h0);
    cmd(pif_pkg::OP_IRQ_ENABLE, 8'h03, pif_pkg::STS_BAD_CSUM);
    `CHK("irq", 1'b0, irq)
    // Error flag clears, one type at a time
    for (int t = 0; t <= 5; t++) begin
      err_set <= 5'h1f;
      @(posedge clk);
      err_set <= 5'h00;
      cmd(pif_pkg::OP_CLEAR_FLAGS, 8'(t), pif_pkg::STS_OK);
      `CHK("err_flags", (t == 0) ? 5'h00 : 5'h1f & ~(5'h01 << (t - 1)), err_flags)
    end
    // Enables, handlers, entry and return
    cmd(pif_pkg::OP_IRQ_ENABLE, 8'h03, pif_pkg::STS_OK);
    cmd(pif_pkg::OP_IRQ_ENABLE, 8'h05, pif_pkg::STS_OK);
    cmd(pif_pkg::OP_IRQ_ENABLE, pif_pkg::IRQ_GLOBAL, pif_pkg::STS_OK);
    rd(pif_pkg::REG_ENABLE, 32'h128);
    pg(pif_pkg::OP_SET_HANDLER, 8'h03, 32'h11);
    pg(pif_pkg::OP_SET_HANDLER, 8'h03, 32'h1234);
    pg(pif_pkg::OP_SET_HANDLER, 8'h05, 32'h55);
    c1 = {32'($urandom), 32'($urandom), 8'($urandom), 16'($urandom)};
    c2 = {32'($urandom), 32'($urandom), 8'($urandom), 16'($urandom)};
    ctx_in <= c1;
    q_jmp.push_back(16'h1234);
    pulse(3);
    drain();
    ctx_in <= c2;
    pulse(5);
    q_rst.push_back(c1);
    q_jmp.push_back(16'h0055);
    pg(pif_pkg::OP_HANDLER_RET, pif_pkg::IRQ_GLOBAL, 32'h0);
    drain();
    q_rst.push_back(c2);
    pg(pif_pkg::OP_HANDLER_RET, pif_pkg::IRQ_GLOBAL, 32'h0);
    drain();
    // Disables and a refused opcode
    cmd(pif_pkg::OP_IRQ_DISABLE, pif_pkg::IRQ_GLOBAL, pif_pkg::STS_OK);
    pulse(3);
    cmd(pif_pkg::OP_IRQ_DISABLE, 8'h03, pif_pkg::STS_OK);
    rd(pif_pkg::REG_ENABLE, 32'h20);
    rd(pif_pkg::REG_HANDLER, 32'h00280800);
    cmd(8'h30, 8'h00, pif_pkg::STS_BAD_CMD);
    // Every event kind seen since the last status read
    rd(pif_pkg::REG_EVENT, 32'hf);
    drain();
    end_sim();
  end
endmodule // testbench

// file: verilog/pif_pkg.sv
package pif_pkg;

  // Sizes
  localparam int NSRC   = 8;
  localparam int NFLAG  = 5;
  localparam int PC_W   = 16;
  localparam int NEV    = 4;

  // Opcodes
  localparam logic [7:0] OP_CLEAR_FLAGS  = 8'h24;
  localparam logic [7:0] OP_IRQ_ENABLE   = 8'h19;
  localparam logic [7:0] OP_IRQ_DISABLE  = 8'h1a;
  localparam logic [7:0] OP_SET_HANDLER  = 8'h25;
  localparam logic [7:0] OP_HANDLER_RET  = 8'h26;

  // Type byte meanings
  localparam logic [7:0] IRQ_GLOBAL      = 8'hff;
  localparam logic [7:0] CLR_ALL         = 8'h00;
  localparam logic [7:0] CLR_TIMEOUT     = 8'h01;
  localparam logic [7:0] CLR_ALARM       = 8'h02;
  localparam logic [7:0] CLR_DEVIATION   = 8'h03;
  localparam logic [7:0] CLR_POSITION    = 8'h04;
  localparam logic [7:0] CLR_SHUTDOWN    = 8'h05;

  // Error flag bits
  localparam int FLG_TIMEOUT   = 0;
  localparam int FLG_ALARM     = 1;
  localparam int FLG_DEVIATION = 2;
  localparam int FLG_POSITION  = 3;
  localparam int FLG_SHUTDOWN  = 4;

  // Reply status codes
  localparam logic [7:0] STS_OK        = 8'h64;
  localparam logic [7:0] STS_BAD_CSUM  = 8'h01;
  localparam logic [7:0] STS_BAD_CMD   = 8'h02;

  // Frame byte positions
  localparam logic [3:0] BYTE_ADDR     = 4'h0;
  localparam logic [3:0] BYTE_OP       = 4'h1;
  localparam logic [3:0] BYTE_TYPE     = 4'h2;
  localparam logic [3:0] BYTE_BANK     = 4'h3;
  localparam logic [3:0] BYTE_VAL3     = 4'h4;
  localparam logic [3:0] BYTE_VAL2     = 4'h5;
  localparam logic [3:0] BYTE_VAL1     = 4'h6;
  localparam logic [3:0] BYTE_VAL0     = 4'h7;
  localparam logic [3:0] BYTE_CSUM     = 4'h8;
  localparam logic [7:0] MODULE_ADDR   = 8'h01;

  // Register byte offsets
  localparam logic [7:0] REG_EVENT     = 8'h00;
  localparam logic [7:0] REG_MASK      = 8'h04;
  localparam logic [7:0] REG_FLAGS     = 8'h08;
  localparam logic [7:0] REG_ENABLE    = 8'h0c;
  localparam logic [7:0] REG_HANDLER   = 8'h10;

  // Event bits
  localparam int EV_CMD_DONE   = 0;
  localparam int EV_CSUM_ERR   = 1;
  localparam int EV_ENTER      = 2;
  localparam int EV_RETURN     = 3;

  // Reset values
  localparam logic [NEV-1:0] MASK_RST  = 4'h0;

  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } pif_cmd_t;

  typedef struct packed {
    logic [31:0]     acc;
    logic [31:0]     x;
    logic [7:0]      flags;
    logic [PC_W-1:0] pc;
  } pif_ctx_t;

  typedef struct packed {
    logic [3:0]                 byte_cnt;
    logic [7:0]                 sum;
    logic [7:0]                 frame_addr;
    pif_cmd_t                   host_cmd;
    logic                       host_pend;
    logic [NFLAG-1:0]           err_flags;
    logic [NSRC-1:0]            src_en;
    logic                       glob_en;
    logic [NSRC-1:0][PC_W-1:0]  set_handler_address_cmd;
    logic [NSRC-1:0]            set_handler_address_cmd_def;
    logic [NSRC-1:0]            pending;
    logic [NSRC-1:0]            src_prev;
    logic                       in_handler;
    pif_ctx_t                   saved;
    logic                       jump_valid;
    logic [PC_W-1:0]            jump_pc;
    logic                       restore_valid;
    pif_ctx_t                   restore;
    logic                       reply_valid;
    logic [7:0]                 reply_status;
    logic [7:0]                 reply_cmd;
    logic [NEV-1:0]             ev_sts;
    logic [NEV-1:0]             ev_mask;
    logic                       irq;
    logic                       wreq;
    logic [31:0]                rdata;
  } pif_state_t;

endpackage

// file: verilog/pif_sync2.sv
`timescale 1ns/1ps
module pif_sync2 #(
  parameter int W = pif_pkg::NSRC
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pif_sync_t;

  pif_sync_t st_ff;
  pif_sync_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;

endmodule // pif_sync2

// file: verilog/pif_top.sv
// Contract
// [RL1] Opcode 36 clears error flags chosen by type; bank and value ignored.
// [RL2] Clear type 0 all, 1 timeout, 2 alarm, 3 deviation, 4 position, 5 shutdown.
// [RL3] Direct commands answer status 100 on success; reply value meaningless.
// [RL4] Opcode 25 enables the source numbered by type; bank and value ignored.
// [RL5] Enable with number 255 sets the global interrupt enable.
// [RL6] Opcode 26 disables the source numbered by type; bank and value ignored.
// [RL7] Disable with number 255 clears the global interrupt enable.
// [RL8] Opcode 37 stores value as handler address for source numbered by type.
// [RL9] A later handler address replaces the stored one.
// [RL10] Opcode 38 ends the running handler, resuming normal execution.
// [RL11] Handler return restores saved accumulator, X, flags and program counter.
// [RL12] Programs end handlers with return and never fall into a handler.
// [RL13] Handler address and return commands belong in stored programs only; the code also runs them from host frames.
// [RL14] Frame: address, opcode, type, bank, value MSB first, checksum.
// [RL15] Checksum is the modulo 256 sum of preceding bytes, compared on receipt.
// [RL16] Enabled source saves context and jumps to its stored handler address.
// [RL17] No new handler starts until the running one has returned.
`timescale 1ns/1ps
module pif_top (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  output logic                             irq,
  // Host frame byte stream
  input  wire logic                        rx_valid,
  input  wire logic [7:0]                  rx_byte,
  output logic                             reply_valid,
  output logic      [7:0]                  reply_status,
  output logic      [7:0]                  reply_cmd,
  // Stored program command
  input  wire logic                        prog_valid,
  input  wire pif_pkg::pif_cmd_t           prog_cmd,
  // Executor context
  input  wire pif_pkg::pif_ctx_t           ctx_in,
  output logic                             jump_valid,
  output logic      [pif_pkg::PC_W-1:0]    jump_pc,
  output logic                             restore_valid,
  output pif_pkg::pif_ctx_t                restore_ctx,
  // Event sources
  input  wire logic [pif_pkg::NSRC-1:0]    irq_src_pin,
  input  wire logic [pif_pkg::NFLAG-1:0]   err_set,
  output logic      [pif_pkg::NFLAG-1:0]   err_flags
);

  pif_pkg::pif_state_t            st_ff;
  pif_pkg::pif_state_t            nxt_st;
  logic [pif_pkg::NSRC-1:0]       src_sync;
  pif_pkg::pif_cmd_t              cmd;
  logic                           exec_go;
  logic                           exec_direct;
  logic                           exec_ok;
  logic [pif_pkg::NFLAG-1:0]      clr_mask;
  logic [pif_pkg::NSRC-1:0]       src_rise;
  logic [pif_pkg::NSRC-1:0]       cand;
  logic [pif_pkg::NSRC-1:0]       take_bit;
  logic                           found;
  logic [2:0]                     sel;
  logic                           num_ok;
  logic [pif_pkg::NEV-1:0]        ev;
  logic                           bus_req;
  logic                           bus_take;
  logic                           bus_done;
  logic                           rd_event;

  pif_sync2 #(
    .W (pif_pkg::NSRC)
  ) u_src_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (irq_src_pin),
    .q     (src_sync)
  );

  always_comb begin
    nxt_st               = st_ff;
    nxt_st.jump_valid    = 1'b0;
    nxt_st.restore_valid = 1'b0;
    nxt_st.reply_valid   = 1'b0;
    cmd                  = prog_cmd;
    exec_go              = 1'b0;
    exec_direct          = 1'b0;
    exec_ok              = 1'b0;
    clr_mask             = '0;
    ev                   = '0;
    found                = 1'b0;
    sel                  = 3'h0;
    take_bit             = '0;

    // Command source, stored program first
    if (prog_valid) begin
      cmd     = prog_cmd;
      exec_go = 1'b1;
    end else if (st_ff.host_pend) begin
      cmd              = st_ff.host_cmd;
      exec_go          = 1'b1;
      exec_direct      = 1'b1;
      nxt_st.host_pend = 1'b0;
    end
    num_ok = (cmd.typ[7:3] == 5'h00);

    // Command execution
    if (exec_go) begin
      case (cmd.op)
        pif_pkg::OP_CLEAR_FLAGS: begin
          exec_ok = 1'b1;
          case (cmd.typ) // see [RL1]
            pif_pkg::CLR_ALL:       clr_mask = '1; // see [RL2]
            pif_pkg::CLR_TIMEOUT:   clr_mask[pif_pkg::FLG_TIMEOUT] = 1'b1; // see [RL2]
            pif_pkg::CLR_ALARM:     clr_mask[pif_pkg::FLG_ALARM] = 1'b1; // see [RL2]
            pif_pkg::CLR_DEVIATION: clr_mask[pif_pkg::FLG_DEVIATION] = 1'b1; // see [RL2]
            pif_pkg::CLR_POSITION:  clr_mask[pif_pkg::FLG_POSITION] = 1'b1; // see [RL2]
            pif_pkg::CLR_SHUTDOWN:  clr_mask[pif_pkg::FLG_SHUTDOWN] = 1'b1; // see [RL2]
            default:                clr_mask = '0;
          endcase
        end
        pif_pkg::OP_IRQ_ENABLE: begin
          exec_ok = 1'b1;
          if (cmd.typ == pif_pkg::IRQ_GLOBAL) begin
            nxt_st.glob_en = 1'b1; // see [RL5]
          end else if (num_ok) begin
            nxt_st.src_en[cmd.typ[2:0]] = 1'b1; // see [RL4]
          end
        end
        pif_pkg::OP_IRQ_DISABLE: begin
          exec_ok = 1'b1;
          if (cmd.typ == pif_pkg::IRQ_GLOBAL) begin
            nxt_st.glob_en = 1'b0; // see [RL7]
          end else if (num_ok) begin
            nxt_st.src_en[cmd.typ[2:0]] = 1'b0; // see [RL6]
          end
        end
        pif_pkg::OP_SET_HANDLER: begin
          exec_ok = 1'b1;
          if (num_ok) begin
            nxt_st.set_handler_address_cmd[cmd.typ[2:0]]     = cmd.value[pif_pkg::PC_W-1:0]; // see [RL8] [RL9]
            nxt_st.set_handler_address_cmd_def[cmd.typ[2:0]] = 1'b1; // see [RL8]
          end
        end
        pif_pkg::OP_HANDLER_RET: begin
          exec_ok = 1'b1;
          if (st_ff.in_handler) begin
            nxt_st.in_handler    = 1'b0; // see [RL10] [RL17]
            nxt_st.restore_valid = 1'b1; // see [RL11]
            nxt_st.restore       = st_ff.saved; // see [RL11]
            ev[pif_pkg::EV_RETURN] = 1'b1;
          end
        end
        default: exec_ok = 1'b0;
      endcase
      if (exec_direct) begin
        nxt_st.reply_valid  = 1'b1;
        nxt_st.reply_cmd    = cmd.op;
        nxt_st.reply_status = exec_ok ? pif_pkg::STS_OK : pif_pkg::STS_BAD_CMD; // see [RL3]
        ev[pif_pkg::EV_CMD_DONE] = 1'b1;
      end
    end

    // Error flags, a new event wins over a clear
    nxt_st.err_flags = (st_ff.err_flags & ~clr_mask) | err_set; // see [RL1]

    // Frame receiver
    if (rx_valid) begin
      if (st_ff.byte_cnt == pif_pkg::BYTE_CSUM) begin
        nxt_st.byte_cnt = 4'h0;
        nxt_st.sum      = 8'h00;
        if (st_ff.frame_addr == pif_pkg::MODULE_ADDR) begin
          if (rx_byte == st_ff.sum) begin // see [RL15]
            nxt_st.host_pend = 1'b1;
          end else begin
            nxt_st.reply_valid  = 1'b1;
            nxt_st.reply_cmd    = st_ff.host_cmd.op;
            nxt_st.reply_status = pif_pkg::STS_BAD_CSUM; // see [RL15]
            ev[pif_pkg::EV_CSUM_ERR] = 1'b1;
          end
        end
      end else begin
        nxt_st.byte_cnt = st_ff.byte_cnt + 4'h1;
        nxt_st.sum      = st_ff.sum + rx_byte; // see [RL15]
        case (st_ff.byte_cnt) // see [RL14]
          pif_pkg::BYTE_ADDR: nxt_st.frame_addr             = rx_byte;
          pif_pkg::BYTE_OP:   nxt_st.host_cmd.op            = rx_byte;
          pif_pkg::BYTE_TYPE: nxt_st.host_cmd.typ           = rx_byte;
          pif_pkg::BYTE_BANK: nxt_st.host_cmd.bank          = rx_byte;
          pif_pkg::BYTE_VAL3: nxt_st.host_cmd.value[31:24]  = rx_byte;
          pif_pkg::BYTE_VAL2: nxt_st.host_cmd.value[23:16]  = rx_byte;
          pif_pkg::BYTE_VAL1: nxt_st.host_cmd.value[15:8]   = rx_byte;
          pif_pkg::BYTE_VAL0: nxt_st.host_cmd.value[7:0]    = rx_byte;
          default:            nxt_st.byte_cnt               = 4'h0;
        endcase
      end
    end

    // Interrupt entry, lowest source number first
    src_rise        = src_sync & ~st_ff.src_prev;
    nxt_st.src_prev = src_sync;
    cand = st_ff.pending & st_ff.src_en & st_ff.set_handler_address_cmd_def;
    for (int i = pif_pkg::NSRC - 1; i >= 0; i--) begin
      if (cand[i]) begin
        found = 1'b1;
        sel   = 3'(i);
      end
    end
    if (found && st_ff.glob_en && !st_ff.in_handler) begin // see [RL16] [RL17]
      nxt_st.in_handler = 1'b1;
      nxt_st.saved      = ctx_in; // see [RL16]
      nxt_st.jump_valid = 1'b1;
      nxt_st.jump_pc    = st_ff.set_handler_address_cmd[sel]; // see [RL16]
      take_bit[sel]     = 1'b1;
      ev[pif_pkg::EV_ENTER] = 1'b1;
    end
    nxt_st.pending = (st_ff.pending & ~take_bit) | src_rise;

    // Avalon-MM slave, one wait cycle
    bus_req  = avs_read || avs_write;
    bus_take = bus_req && st_ff.wreq;
    bus_done = bus_req && !st_ff.wreq;
    nxt_st.wreq = !bus_take;
    rd_event = bus_done && avs_read && (avs_address == pif_pkg::REG_EVENT);
    if (bus_take) begin
      if (avs_read) begin
        nxt_st.rdata = 32'h0000_0000;
        case (avs_address)
          pif_pkg::REG_EVENT:   nxt_st.rdata[pif_pkg::NEV-1:0]   = st_ff.ev_sts;
          pif_pkg::REG_MASK:    nxt_st.rdata[pif_pkg::NEV-1:0]   = st_ff.ev_mask;
          pif_pkg::REG_FLAGS:   nxt_st.rdata[pif_pkg::NFLAG-1:0] = st_ff.err_flags;
          pif_pkg::REG_ENABLE:  nxt_st.rdata[8:0]  = {st_ff.glob_en, st_ff.src_en};
          pif_pkg::REG_HANDLER: nxt_st.rdata[23:0] = {st_ff.set_handler_address_cmd_def, st_ff.pending, 7'h00, st_ff.in_handler};
          default:              nxt_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (bus_done && avs_write && (avs_address == pif_pkg::REG_MASK) && avs_byteenable[0]) begin
      nxt_st.ev_mask = avs_writedata[pif_pkg::NEV-1:0];
    end
    // Read clears only the bits it returned
    nxt_st.ev_sts = (st_ff.ev_sts & ~(rd_event ? st_ff.rdata[pif_pkg::NEV-1:0] : '0)) | ev;
    nxt_st.irq    = |(nxt_st.ev_sts & nxt_st.ev_mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff         <= '0;
      st_ff.wreq    <= 1'b1;
      st_ff.ev_mask <= pif_pkg::MASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.wreq;
  assign irq             = st_ff.irq;
  assign reply_valid     = st_ff.reply_valid;
  assign reply_status    = st_ff.reply_status;
  assign reply_cmd       = st_ff.reply_cmd;
  assign jump_valid      = st_ff.jump_valid;
  assign jump_pc         = st_ff.jump_pc;
  assign restore_valid   = st_ff.restore_valid;
  assign restore_ctx     = st_ff.restore;
  assign err_flags       = st_ff.err_flags;

endmodule // pif_top
